//--- rtl/debug_regs_pkg.sv
// Constants, register indices and field layout of the debug register bank
// Contract
// - Debug entry copies the thread's saved pc into a read-write register.
// - Debug entry copies the saved sp into a second read-write register.
// - Bits 7:0 name the thread a register fetch reads; the rest is reserved.
// - Bits 4:0 select which register of that thread the fetch returns.
// - Bits 2:0 hold cause 1-5: host, call, ibreak, dwatch, rwatch; reset 0.
// - Bits 17:16 hold the lowest firing trigger index; zero for host, call.
// - Bits 15:8 hold the causing thread number; zero for host requests.
// - Data watch hit stores access address; resource hit stores resource id.
// - Bits 7:0 mark threads that stay stopped on return from debug.
// - Eight scratch words at 0x20-0x27, shared with tile config space.
// - Four 32-bit instruction breakpoints raise a debug interrupt on match.
// - Per-thread enable mask in control bits 23:16, reset zero.
// - Control bit 1 picks equal (0) or not-equal (1) pc match, reset zero.
// - Control bit 0 enables a breakpoint; disabled ones never interrupt.
// - First address of each of four data watchpoints at 0x50-0x53.
// - Second address of each of four data watchpoints at 0x60-0x63.
// - Watch condition bit 0 means A and B, 1 means A or B.
// - Data watchpoints fire on loads only when their load bit is set.
package debug_regs_pkg;

  // Register indices; the byte address on the port is four times these
  localparam logic [7:0] IDX_SAVED_PC = 8'h11;
  localparam logic [7:0] IDX_SAVED_SP = 8'h12;
  localparam logic [7:0] IDX_FETCH_THREAD = 8'h13;
  localparam logic [7:0] IDX_FETCH_REG = 8'h14;
  localparam logic [7:0] IDX_CAUSE = 8'h15;
  localparam logic [7:0] IDX_EVENT_DATA = 8'h16;
  localparam logic [7:0] IDX_RUN_STOP = 8'h18;
  localparam logic [7:0] IDX_EVT_STATUS = 8'h1a;
  localparam logic [7:0] IDX_EVT_MASK = 8'h1b;
  localparam logic [7:0] IDX_SCRATCH = 8'h20;
  localparam logic [7:0] IDX_IBRK_ADDR = 8'h30;
  localparam logic [7:0] IDX_IBRK_CTRL = 8'h40;
  localparam logic [7:0] IDX_DW_ADDR_A = 8'h50;
  localparam logic [7:0] IDX_DW_ADDR_B = 8'h60;
  localparam logic [7:0] IDX_DW_CTRL = 8'h70;

  // Bank masks: low index bits that pick the word inside a bank
  localparam logic [7:0] BANK4_MASK = 8'h03;
  localparam logic [7:0] BANK8_MASK = 8'h07;

  // Field positions
  localparam int unsigned CAUSE_CODE_LSB = 0;
  localparam int unsigned CAUSE_THREAD_LSB = 8;
  localparam int unsigned CAUSE_INDEX_LSB = 16;
  localparam int unsigned BREAKPOINT_ON_BIT = 0;
  localparam int unsigned MATCH_SENSE_BIT = 1;
  localparam int unsigned WATCH_COND_BIT = 1;
  localparam int unsigned WATCH_LOAD_BIT = 2;
  localparam int unsigned THREAD_MASK_LSB = 16;

  // Event bits of the status and mask registers
  localparam int unsigned EVT_HOST = 0;
  localparam int unsigned EVT_CALL = 1;
  localparam int unsigned EVT_IBRK = 2;
  localparam int unsigned EVT_DWATCH = 3;
  localparam int unsigned EVT_RWATCH = 4;
  localparam int unsigned EVT_W = 5;

  // Values after reset
  localparam logic [31:0] WORD_RESET = 32'h0;
  localparam logic [7:0] BYTE_RESET = 8'h0;
  localparam logic [EVT_W-1:0] EVT_RESET = 5'h0;

  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b000,
    CAUSE_HOST = 3'b001,
    CAUSE_CALL = 3'b010,
    CAUSE_IBRK = 3'b011,
    CAUSE_DWATCH = 3'b100,
    CAUSE_RWATCH = 3'b101
  } debug_cause_t;

endpackage

//--- rtl/debug_regs.sv
// Debug state capture, breakpoint matching and debugger register bank
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module debug_regs
  import debug_regs_pkg::*;
#(
  parameter int unsigned NUM_THREADS = 8,
  parameter int unsigned NUM_BREAKS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port, byte addresses
  input wire logic [9:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  // Tile configuration view of the scratch words
  input wire logic [2:0] cfgAddr,
  input wire logic [31:0] cfgWrData,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  output logic [31:0] cfgRdData,
  // Core state
  input wire logic debugActive,
  input wire logic debugEntry,
  input wire logic debugExit,
  input wire logic [31:0] entryPc,
  input wire logic [31:0] entrySp,
  // Trigger sources
  input wire logic hostReq,
  input wire logic callReq,
  input wire logic [7:0] callThread,
  input wire logic pcValid,
  input wire logic [2:0] pcThread,
  input wire logic [31:0] pcValue,
  input wire logic memValid,
  input wire logic memLoad,
  input wire logic [2:0] memThread,
  input wire logic [31:0] memAddr,
  input wire logic rwatchHit,
  input wire logic [1:0] rwatchIndex,
  input wire logic [7:0] rwatchThread,
  input wire logic [31:0] rwatchResId,
  // Results to the core
  output logic debugIrqReq,
  output logic [7:0] threadHold,
  output logic [7:0] fetchThreadIndex,
  output logic [4:0] fetchRegisterIndex,
  output logic irq
);

  // The thread mask fields are eight bits and indices two bits wide
  if (NUM_THREADS != 8 || NUM_BREAKS != 4) begin : g_check
    $error("debug_regs supports exactly 8 threads and 4 breakpoints");
  end

  // Lowest set bit of a four-way hit vector
  function automatic logic [1:0] lowestIdx(input logic [3:0] hits);
    logic [1:0] idx;
    idx = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (hits[k]) begin
        idx = 2'(k);
      end
    end
    return idx;
  endfunction

  // True when an index falls in the bank at base
  function automatic logic inBank(input logic [7:0] idx,
                                  input logic [7:0] base,
                                  input logic [7:0] mask);
    return (idx & ~mask) == base;
  endfunction

  // Reset release through two flops
  logic [1:0] rstSync_r;
  logic rstN;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  // State
  logic [31:0] savedPc_r, savedPc_nxt;
  logic [31:0] savedSp_r, savedSp_nxt;
  logic [7:0] fetchThread_r, fetchThread_nxt;
  logic [4:0] fetchReg_r, fetchReg_nxt;
  debug_cause_t cause_r, cause_nxt;
  logic [7:0] causeThread_r, causeThread_nxt;
  logic [1:0] causeIndex_r, causeIndex_nxt;
  logic [31:0] eventData_r, eventData_nxt;
  logic [7:0] runStop_r, runStop_nxt;
  logic [7:0] threadHold_r, threadHold_nxt;
  logic [31:0] scratch_r [8];
  logic [31:0] scratch_nxt [8];
  logic [31:0] ibAddr_r [4];
  logic [31:0] ibAddr_nxt [4];
  logic [7:0] ibThreads_r [4];
  logic [7:0] ibThreads_nxt [4];
  logic [3:0] ibSense_r, ibSense_nxt;
  logic [3:0] ibOn_r, ibOn_nxt;
  logic [31:0] dwA_r [4];
  logic [31:0] dwA_nxt [4];
  logic [31:0] dwB_r [4];
  logic [31:0] dwB_nxt [4];
  logic [7:0] dwThreads_r [4];
  logic [7:0] dwThreads_nxt [4];
  logic [3:0] dwLoad_r, dwLoad_nxt;
  logic [3:0] dwCond_r, dwCond_nxt;
  logic [3:0] dwOn_r, dwOn_nxt;
  logic [EVT_W-1:0] evtStatus_r, evtStatus_nxt;
  logic [EVT_W-1:0] evtMask_r, evtMask_nxt;
  logic irq_r, irq_nxt;
  logic debugIrq_r, debugIrq_nxt;
  logic [31:0] regRdData_r, regRdData_nxt;
  logic [31:0] cfgRdData_r, cfgRdData_nxt;

  // Decoded access
  logic [7:0] idx;
  logic aligned;
  logic wrAny;
  logic wrDbg;

  assign idx = regAddr[9:2];
  assign aligned = regAddr[1:0] == 2'h0;
  assign wrAny = regWrEn && aligned;
  assign wrDbg = wrAny && debugActive;

  // Trigger matching
  logic [3:0] ibHit;
  logic [3:0] dwHit;
  logic fire;

  always_comb begin
    logic condA;
    logic condB;
    logic cond;
    condA = 1'b0;
    condB = 1'b0;
    cond = 1'b0;
    for (int i = 0; i < 4; i++) begin
      // Disabled entries and unlisted threads never match
      ibHit[i] = ibOn_r[i] && pcValid && ibThreads_r[i][pcThread] &&
                 (ibSense_r[i] ? (pcValue != ibAddr_r[i]) :
                                 (pcValue == ibAddr_r[i]));
      condA = memAddr >= dwA_r[i];
      condB = memAddr <= dwB_r[i];
      cond = dwCond_r[i] ? (condA || condB) : (condA && condB);
      dwHit[i] = dwOn_r[i] && memValid && dwThreads_r[i][memThread] &&
                 (!memLoad || dwLoad_r[i]) && cond;
    end
  end

  // One request at a time: held until the core enters debug mode
  assign fire = !debugActive && !debugIrq_r &&
                (hostReq || callReq || (|ibHit) || (|dwHit) || rwatchHit);

  // Next state of the whole bank
  always_comb begin
    logic [EVT_W-1:0] evtSet;
    logic [EVT_W-1:0] evtClr;
    evtSet = EVT_RESET;
    evtClr = EVT_RESET;
    savedPc_nxt = savedPc_r;
    savedSp_nxt = savedSp_r;
    fetchThread_nxt = fetchThread_r;
    fetchReg_nxt = fetchReg_r;
    cause_nxt = cause_r;
    causeThread_nxt = causeThread_r;
    causeIndex_nxt = causeIndex_r;
    eventData_nxt = eventData_r;
    runStop_nxt = runStop_r;
    threadHold_nxt = threadHold_r;
    scratch_nxt = scratch_r;
    ibAddr_nxt = ibAddr_r;
    ibThreads_nxt = ibThreads_r;
    ibSense_nxt = ibSense_r;
    ibOn_nxt = ibOn_r;
    dwA_nxt = dwA_r;
    dwB_nxt = dwB_r;
    dwThreads_nxt = dwThreads_r;
    dwLoad_nxt = dwLoad_r;
    dwCond_nxt = dwCond_r;
    dwOn_nxt = dwOn_r;
    evtMask_nxt = evtMask_r;
    debugIrq_nxt = debugIrq_r;

    // Software writes to debug registers, only in debug mode
    if (wrDbg) begin
      case (idx)
        IDX_SAVED_PC: savedPc_nxt = regWrData;
        IDX_SAVED_SP: savedSp_nxt = regWrData;
        IDX_FETCH_THREAD: fetchThread_nxt = regWrData[7:0];
        IDX_FETCH_REG: fetchReg_nxt = regWrData[4:0];
        IDX_CAUSE: begin
          cause_nxt = debug_cause_t'(regWrData[CAUSE_CODE_LSB +: 3]);
          causeThread_nxt = regWrData[CAUSE_THREAD_LSB +: 8];
          causeIndex_nxt = regWrData[CAUSE_INDEX_LSB +: 2];
        end
        IDX_EVENT_DATA: eventData_nxt = regWrData;
        IDX_RUN_STOP: runStop_nxt = regWrData[7:0];
        default: begin
        end
      endcase
      if (inBank(idx, IDX_SCRATCH, BANK8_MASK)) begin
        scratch_nxt[idx[2:0]] = regWrData;
      end
      if (inBank(idx, IDX_IBRK_ADDR, BANK4_MASK)) begin
        ibAddr_nxt[idx[1:0]] = regWrData;
      end
      if (inBank(idx, IDX_IBRK_CTRL, BANK4_MASK)) begin
        ibThreads_nxt[idx[1:0]] = regWrData[THREAD_MASK_LSB +: 8];
        ibSense_nxt[idx[1:0]] = regWrData[MATCH_SENSE_BIT];
        ibOn_nxt[idx[1:0]] = regWrData[BREAKPOINT_ON_BIT];
      end
      if (inBank(idx, IDX_DW_ADDR_A, BANK4_MASK)) begin
        dwA_nxt[idx[1:0]] = regWrData;
      end
      if (inBank(idx, IDX_DW_ADDR_B, BANK4_MASK)) begin
        dwB_nxt[idx[1:0]] = regWrData;
      end
      if (inBank(idx, IDX_DW_CTRL, BANK4_MASK)) begin
        dwThreads_nxt[idx[1:0]] = regWrData[THREAD_MASK_LSB +: 8];
        dwLoad_nxt[idx[1:0]] = regWrData[WATCH_LOAD_BIT];
        dwCond_nxt[idx[1:0]] = regWrData[WATCH_COND_BIT];
        dwOn_nxt[idx[1:0]] = regWrData[BREAKPOINT_ON_BIT];
      end
    end

    // Interrupt status and mask are reachable outside debug mode
    if (wrAny && idx == IDX_EVT_STATUS) begin
      evtClr = regWrData[EVT_W-1:0];
    end
    if (wrAny && idx == IDX_EVT_MASK) begin
      evtMask_nxt = regWrData[EVT_W-1:0];
    end

    // Configuration space writes scratch unless the bus hits the same word
    if (cfgWrEn && !(wrDbg && inBank(idx, IDX_SCRATCH, BANK8_MASK) &&
                     idx[2:0] == cfgAddr)) begin
      scratch_nxt[cfgAddr] = cfgWrData;
    end

    // Record the winning trigger; host first, resource watch last
    if (fire) begin
      debugIrq_nxt = 1'b1;
      if (hostReq) begin
        cause_nxt = CAUSE_HOST;
        causeThread_nxt = BYTE_RESET;
        causeIndex_nxt = 2'h0;
        evtSet[EVT_HOST] = 1'b1;
      end else if (callReq) begin
        cause_nxt = CAUSE_CALL;
        causeThread_nxt = callThread;
        causeIndex_nxt = 2'h0;
        evtSet[EVT_CALL] = 1'b1;
      end else if (|ibHit) begin
        cause_nxt = CAUSE_IBRK;
        causeThread_nxt = {5'h0, pcThread};
        causeIndex_nxt = lowestIdx(ibHit);
        evtSet[EVT_IBRK] = 1'b1;
      end else if (|dwHit) begin
        cause_nxt = CAUSE_DWATCH;
        causeThread_nxt = {5'h0, memThread};
        causeIndex_nxt = lowestIdx(dwHit);
        eventData_nxt = memAddr;
        evtSet[EVT_DWATCH] = 1'b1;
      end else begin
        cause_nxt = CAUSE_RWATCH;
        causeThread_nxt = rwatchThread;
        causeIndex_nxt = rwatchIndex;
        eventData_nxt = rwatchResId;
        evtSet[EVT_RWATCH] = 1'b1;
      end
    end

    // Entry captures the interrupted context and ends the request
    if (debugEntry) begin
      savedPc_nxt = entryPc;
      savedSp_nxt = entrySp;
      debugIrq_nxt = 1'b0;
      threadHold_nxt = BYTE_RESET;
    end
    // Threads marked in the run-stop mask stay parked after return
    if (debugExit) begin
      threadHold_nxt = runStop_r;
    end

    // A new event beats a clear in the same cycle
    evtStatus_nxt = (evtStatus_r & ~evtClr) | evtSet;
    irq_nxt = |(evtStatus_nxt & evtMask_nxt);
  end

  // Read data, one cycle after the strobe; reserved bits read zero
  always_comb begin
    regRdData_nxt = WORD_RESET;
    if (regRdEn && aligned) begin
      case (idx)
        IDX_SAVED_PC: regRdData_nxt = savedPc_r;
        IDX_SAVED_SP: regRdData_nxt = savedSp_r;
        IDX_FETCH_THREAD: regRdData_nxt = {24'h0, fetchThread_r};
        IDX_FETCH_REG: regRdData_nxt = {27'h0, fetchReg_r};
        IDX_CAUSE: regRdData_nxt = {14'h0, causeIndex_r, causeThread_r,
                                    5'h0, cause_r};
        IDX_EVENT_DATA: regRdData_nxt = eventData_r;
        IDX_RUN_STOP: regRdData_nxt = {24'h0, runStop_r};
        IDX_EVT_STATUS: regRdData_nxt = {27'h0, evtStatus_r};
        IDX_EVT_MASK: regRdData_nxt = {27'h0, evtMask_r};
        default: begin
        end
      endcase
      if (inBank(idx, IDX_SCRATCH, BANK8_MASK)) begin
        regRdData_nxt = scratch_r[idx[2:0]];
      end
      if (inBank(idx, IDX_IBRK_ADDR, BANK4_MASK)) begin
        regRdData_nxt = ibAddr_r[idx[1:0]];
      end
      if (inBank(idx, IDX_IBRK_CTRL, BANK4_MASK)) begin
        regRdData_nxt = {8'h0, ibThreads_r[idx[1:0]], 14'h0,
                         ibSense_r[idx[1:0]], ibOn_r[idx[1:0]]};
      end
      if (inBank(idx, IDX_DW_ADDR_A, BANK4_MASK)) begin
        regRdData_nxt = dwA_r[idx[1:0]];
      end
      if (inBank(idx, IDX_DW_ADDR_B, BANK4_MASK)) begin
        regRdData_nxt = dwB_r[idx[1:0]];
      end
      if (inBank(idx, IDX_DW_CTRL, BANK4_MASK)) begin
        regRdData_nxt = {8'h0, dwThreads_r[idx[1:0]], 13'h0,
                         dwLoad_r[idx[1:0]], dwCond_r[idx[1:0]],
                         dwOn_r[idx[1:0]]};
      end
    end
    cfgRdData_nxt = cfgRdEn ? scratch_r[cfgAddr] : WORD_RESET;
  end

  // Registers; breakpoints come up disabled so nothing fires early
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      savedPc_r <= WORD_RESET;
      savedSp_r <= WORD_RESET;
      fetchThread_r <= BYTE_RESET;
      fetchReg_r <= 5'h0;
      cause_r <= CAUSE_NONE;
      causeThread_r <= BYTE_RESET;
      causeIndex_r <= 2'h0;
      eventData_r <= WORD_RESET;
      runStop_r <= BYTE_RESET;
      threadHold_r <= BYTE_RESET;
      for (int i = 0; i < 8; i++) begin
        scratch_r[i] <= WORD_RESET;
      end
      for (int i = 0; i < 4; i++) begin
        ibAddr_r[i] <= WORD_RESET;
        ibThreads_r[i] <= BYTE_RESET;
        dwA_r[i] <= WORD_RESET;
        dwB_r[i] <= WORD_RESET;
        dwThreads_r[i] <= BYTE_RESET;
      end
      ibSense_r <= 4'h0;
      ibOn_r <= 4'h0;
      dwLoad_r <= 4'h0;
      dwCond_r <= 4'h0;
      dwOn_r <= 4'h0;
      evtStatus_r <= EVT_RESET;
      evtMask_r <= EVT_RESET;
      irq_r <= 1'b0;
      debugIrq_r <= 1'b0;
      regRdData_r <= WORD_RESET;
      cfgRdData_r <= WORD_RESET;
    end else begin
      savedPc_r <= savedPc_nxt;
      savedSp_r <= savedSp_nxt;
      fetchThread_r <= fetchThread_nxt;
      fetchReg_r <= fetchReg_nxt;
      cause_r <= cause_nxt;
      causeThread_r <= causeThread_nxt;
      causeIndex_r <= causeIndex_nxt;
      eventData_r <= eventData_nxt;
      runStop_r <= runStop_nxt;
      threadHold_r <= threadHold_nxt;
      scratch_r <= scratch_nxt;
      ibAddr_r <= ibAddr_nxt;
      ibThreads_r <= ibThreads_nxt;
      dwA_r <= dwA_nxt;
      dwB_r <= dwB_nxt;
      dwThreads_r <= dwThreads_nxt;
      ibSense_r <= ibSense_nxt;
      ibOn_r <= ibOn_nxt;
      dwLoad_r <= dwLoad_nxt;
      dwCond_r <= dwCond_nxt;
      dwOn_r <= dwOn_nxt;
      evtStatus_r <= evtStatus_nxt;
      evtMask_r <= evtMask_nxt;
      irq_r <= irq_nxt;
      debugIrq_r <= debugIrq_nxt;
      regRdData_r <= regRdData_nxt;
      cfgRdData_r <= cfgRdData_nxt;
    end
  end

  // Outputs straight from flops
  assign regRdData = regRdData_r;
  assign cfgRdData = cfgRdData_r;
  assign debugIrqReq = debugIrq_r;
  assign threadHold = threadHold_r;
  assign fetchThreadIndex = fetchThread_r;
  assign fetchRegisterIndex = fetchReg_r;
  assign irq = irq_r;

endmodule // debug_regs

//--- bench/debug_core_model.sv
// Behavioural core and debugger side that enters and leaves debug mode
`timescale 1ns/10ps
module debug_core_model #(
  parameter logic [31:0] PC = 32'h0000_4a30,
  parameter logic [31:0] SP = 32'h0001_ff00
) (
  input wire logic sys_clk,
  input wire logic debugIrqReq,
  input wire logic leave,
  input wire logic [3:0] lat,
  output logic debugActive,
  output logic debugEntry,
  output logic debugExit,
  output logic [31:0] entryPc,
  output logic [31:0] entrySp
);
  int cnt = 0;
  initial begin
    {debugActive, debugEntry, debugExit} = 3'b000;
    entryPc = PC;
    entrySp = SP;
  end
  // Enter after lat cycles; pc and sp are only true beside the entry pulse
  always @(posedge sys_clk) begin
    debugEntry <= 1'b0;
    debugExit <= 1'b0;
    entryPc <= ~entryPc;
    entrySp <= ~entrySp;
    if (debugIrqReq && !debugActive && !debugEntry) begin
      cnt <= cnt + 1;
      if (cnt >= lat) begin
        cnt <= 0;
        debugEntry <= 1'b1;
        debugActive <= 1'b1;
        entryPc <= PC;
        entrySp <= SP;
      end
    end
    // Leaving is commanded by the bench
    if (leave && debugActive) begin
      debugExit <= 1'b1;
      debugActive <= 1'b0;
    end
  end
endmodule // debug_core_model

//--- bench/debug_regs_assertions.sv
// Port-level timing checks of the debug register bank
`timescale 1ns/10ps
module debug_regs_assertions (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic cfgRdEn,
  input wire logic [31:0] cfgRdData,
  input wire logic debugActive,
  input wire logic debugEntry,
  input wire logic debugExit,
  input wire logic hostReq,
  input wire logic debugIrqReq,
  input wire logic [7:0] threadHold,
  input wire logic [7:0] fetchThreadIndex
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Read data stand only in the slot after a strobe
  chk_rd_idle: assert property (
    !$past(regRdEn) |-> regRdData == 32'h0)
    else $error("bus read data outside its slot");
  chk_cfg_idle: assert property (
    !$past(cfgRdEn) |-> cfgRdData == 32'h0)
    else $error("config read data outside its slot");
  // Requests start only while the core runs, and wait for the entry
  chk_req_start: assert property (
    $rose(debugIrqReq) |-> !$past(debugActive))
    else $error("debug request raised in debug mode");
  chk_req_holds: assert property (
    debugIrqReq && !debugEntry |=> debugIrqReq)
    else $error("debug request dropped before entry");
  chk_entry_clears: assert property (
    debugEntry |=> !debugIrqReq && threadHold == 8'h00)
    else $error("entry did not clear request and hold");
  chk_host_taken: assert property (
    hostReq && !debugActive && !debugIrqReq |=> debugIrqReq)
    else $error("host request not taken");
  chk_active_drop: assert property (
    debugActive && !debugIrqReq |=> !debugIrqReq)
    else $error("trigger taken in debug mode");
  // Hold mask moves only at entry or exit; fetch thread moves only after a write
  chk_hold_cause: assert property (
    $changed(threadHold) |-> $past(debugExit) || $past(debugEntry))
    else $error("thread hold changed without entry or exit");
  chk_fetch_write: assert property (
    $changed(fetchThreadIndex) |-> $past(regWrEn) || $past(regWrEn, 2))
    else $error("fetch thread operand changed without a write");
endmodule // debug_regs_assertions

bind debug_regs debug_regs_assertions u_chk (.*);

//--- bench/testbench.sv
// Self-checking bench for the debug register bank
`timescale 1ns/10ps
module testbench;
  import debug_regs_pkg::*;
  logic sys_clk, rst_b, regWrEn, regRdEn, cfgWrEn, cfgRdEn, leave;
  logic [9:0] regAddr;
  logic [31:0] regWrData, regRdData, cfgWrData, cfgRdData;
  logic [2:0] cfgAddr, pcThread, memThread;
  logic debugActive, debugEntry, debugExit, debugIrqReq, irq;
  logic [31:0] entryPc, entrySp, pcValue, memAddr, rwatchResId;
  logic hostReq, callReq, pcValid, memValid, memLoad, rwatchHit;
  logic [7:0] callThread, rwatchThread, threadHold, fetchThreadIndex;
  logic [1:0] rwatchIndex;
  logic [4:0] fetchRegisterIndex;
  logic [3:0] lat;
  int nErrors = 0;
  int compares = 0;

  debug_regs u_debug_regs (.*);
  debug_core_model u_debug_core_model (.*);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("Mismatches %0d, compares %0d", nErrors, compares);
    if (nErrors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Bus cycles start right after a rising edge
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    regAddr <= {idx, 2'b00};
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    // Gap edge, so a following write never sets the strobe twice in a step
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    regAddr <= {idx, 2'b00};
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData, exp);
    @(posedge sys_clk);
  endtask

  // Bounded wait on the debug mode level; a hang ends the run
  task automatic waitAct(input logic v);
    for (int i = 0; i < 40 && debugActive !== v; i++) @(negedge sys_clk);
    if (debugActive !== v) begin
      nErrors++;
      $display("[ERR] %0t wait got %h exp %h", $time, debugActive, v);
      test_done();
    end
    @(posedge sys_clk);
  endtask

  task automatic caught(input logic [31:0] c);
    waitAct(1'b1);
    rd(IDX_CAUSE, c);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_EVT_STATUS, 32'h1f);
    rd(IDX_EVT_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic leaveDbg(input logic [7:0] hold);
    leave <= 1'b1;
    @(posedge sys_clk);
    leave <= 1'b0;
    waitAct(1'b0);
    @(negedge sys_clk);
    chk({24'h0, threadHold}, {24'h0, hold});
    @(posedge sys_clk);
  endtask

  task automatic t_reset();
    rd(IDX_IBRK_CTRL, 32'h0);
    rd(IDX_CAUSE, 32'h0);
    rd(8'hfd, 32'h0);
    wr(IDX_IBRK_CTRL, 32'h0000_0003);
    rd(IDX_IBRK_CTRL, 32'h0);
    wr(IDX_EVT_MASK, 32'h1f);
  endtask

  task automatic t_host();
    hostReq <= 1'b1;
    @(posedge sys_clk);
    hostReq <= 1'b0;
    caught(32'h0000_0001);
    rd(IDX_SAVED_PC, 32'h0000_4a30);
    rd(IDX_SAVED_SP, 32'h0001_ff00);
  endtask

  // All-ones written and read back, then cleared again
  task automatic t_regs();
    logic [7:0] ix [10] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h18, 8'h33,
      8'h42, 8'h53, 8'h63, 8'h15};
    logic [31:0] ex [10] = '{32'hffffffff, 32'hffffffff, 32'hff, 32'h1f,
      32'hff, 32'hffffffff, 32'h00ff0003, 32'hffffffff, 32'hffffffff,
      32'h0003ff07};
    for (int i = 0; i < 10; i++) begin
      wr(ix[i], 32'hffff_ffff);
      rd(ix[i], ex[i]);
    end
    chk({24'h0, fetchThreadIndex}, 32'hff);
    chk({27'h0, fetchRegisterIndex}, 32'h1f);
    for (int i = 0; i < 10; i++) wr(ix[i], 32'h0);
  endtask

  task automatic t_scratch();
    cfgAddr <= 3'h5;
    cfgWrData <= 32'h5a5a_0005;
    cfgWrEn <= 1'b1;
    @(posedge sys_clk);
    cfgWrEn <= 1'b0;
    rd(8'h25, 32'h5a5a_0005);
    wr(8'h22, 32'hc3c3_0002);
    cfgAddr <= 3'h2;
    cfgRdEn <= 1'b1;
    @(posedge sys_clk);
    cfgRdEn <= 1'b0;
    @(negedge sys_clk);
    chk(cfgRdData, 32'hc3c3_0002);
    @(posedge sys_clk);
  endtask

  // Thread 3 is masked out; breakpoints 1 and 2 hit together
  task automatic t_ibrk();
    wr(8'h31, 32'h100);
    wr(8'h32, 32'h100);
    wr(8'h41, 32'h0004_0001);
    wr(8'h42, 32'h0004_0001);
    wr(IDX_RUN_STOP, 32'h10);
    leaveDbg(8'h10);
    pcValue <= 32'h100;
    pcThread <= 3'd3;
    pcValid <= 1'b1;
    @(posedge sys_clk);
    pcThread <= 3'd2;
    @(posedge sys_clk);
    pcValid <= 1'b0;
    caught(32'h0001_0203);
  endtask

  // Not-equal sense on 0; breakpoint 1 would match but is switched off
  task automatic t_sense();
    wr(8'h40, 32'h0004_0003);
    wr(8'h30, 32'h100);
    wr(8'h41, 32'h0004_0000);
    wr(8'h42, 32'h0);
    leaveDbg(8'h10);
    pcValid <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, debugIrqReq}, 32'h0);
    @(posedge sys_clk);
    pcValue <= 32'h104;
    @(posedge sys_clk);
    pcValid <= 1'b0;
    caught(32'h0000_0203);
  endtask

  // Range 0x200..0x2ff on watchpoint 3: load skipped, outside skipped
  task automatic t_dwatch();
    wr(8'h40, 32'h0);
    wr(8'h53, 32'h200);
    wr(8'h63, 32'h2ff);
    wr(8'h73, 32'h0001_0001);
    leaveDbg(8'h10);
    memThread <= 3'd0;
    for (int i = 0; i < 3; i++) begin
      memAddr <= (i == 1) ? 32'h300 : 32'h280;
      memLoad <= (i == 0);
      memValid <= 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk({31'h0, debugIrqReq}, {31'h0, i == 2});
      @(posedge sys_clk);
    end
    memValid <= 1'b0;
    caught(32'h0003_0004);
    rd(IDX_EVENT_DATA, 32'h280);
    // OR condition with loads on: a load below the range still fires
    wr(8'h73, 32'h0001_0007);
    leaveDbg(8'h10);
    {memAddr, memLoad, memValid} <= {32'h100, 2'b11};
    @(posedge sys_clk);
    memValid <= 1'b0;
    caught(32'h0003_0004);
    rd(IDX_EVENT_DATA, 32'h100);
  endtask

  // Slow partner; then a call beats a resource hit in the same cycle
  task automatic t_trig();
    wr(8'h73, 32'h0);
    lat <= 4'd6;
    leaveDbg(8'h10);
    rwatchIndex <= 2'd2;
    rwatchThread <= 8'h05;
    rwatchResId <= 32'h0000_0abc;
    rwatchHit <= 1'b1;
    @(posedge sys_clk);
    rwatchHit <= 1'b0;
    caught(32'h0002_0505);
    rd(IDX_EVENT_DATA, 32'h0000_0abc);
    lat <= 4'd0;
    leaveDbg(8'h10);
    callThread <= 8'h06;
    callReq <= 1'b1;
    rwatchHit <= 1'b1;
    @(posedge sys_clk);
    {callReq, rwatchHit} <= 2'b00;
    caught(32'h0000_0602);
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    {regWrEn, regRdEn, cfgWrEn, cfgRdEn, leave, hostReq} = '0;
    {callReq, pcValid, memValid, memLoad, rwatchHit} = '0;
    {regAddr, regWrData, cfgAddr, cfgWrData, lat} = '0;
    {pcThread, memThread, pcValue, memAddr, rwatchResId} = '0;
    {callThread, rwatchThread, rwatchIndex} = '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_host();
    t_regs();
    t_scratch();
    t_ibrk();
    t_sense();
    t_dwatch();
    t_trig();
    test_done();
  end
endmodule // testbench
